// ### hdl/sref_bist.sv
// Stuck-at-zero self-test sequencer for the error-flag inputs.
`timescale 1ns/1ps
module sref_bist (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Start request on exit from low-power mode.
  input wire logic start,
  // Test control.
  output logic inject,
  output logic check,
  output logic busy
);

  typedef struct packed {
    sref_pkg::sref_bist_e state;
    logic [3:0] cnt;
  } sref_bist_state_s;

  sref_bist_state_s st_q;
  sref_bist_state_s st_d;

  always_comb begin
    st_d = st_q;
    unique case (st_q.state)
      sref_pkg::SREF_IDLE: begin
        if (start) begin
          st_d.state = sref_pkg::SREF_INJECT;
          st_d.cnt = 4'h0;
        end
      end
      sref_pkg::SREF_INJECT: begin
        st_d.cnt = st_q.cnt + 4'h1;
        if (st_q.cnt == sref_pkg::BIST_SETTLE_CYC) begin
          st_d.state = sref_pkg::SREF_CHECK;
        end
      end
      sref_pkg::SREF_CHECK: begin
        st_d.state = sref_pkg::SREF_IDLE;
      end
      default: begin
        st_d.state = sref_pkg::SREF_IDLE;
      end
    endcase
  end

  // The test runs once straight out of reset, which is the power-on case.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q.state <= sref_pkg::SREF_INJECT;
      st_q.cnt <= 4'h0;
    end else begin
      st_q <= st_d;
    end
  end

  // Injection is held through the check cycle so the sampled inputs are high.
  assign inject = (st_q.state != sref_pkg::SREF_IDLE);
  assign check = (st_q.state == sref_pkg::SREF_CHECK);
  assign busy = (st_q.state != sref_pkg::SREF_IDLE);

endmodule : sref_bist

// ### hdl/sref_flags_top.sv
// Redundant error-flag register with its fault latching and read clearing.
`timescale 1ns/1ps
module sref_flags_top (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Register read port from the serial interface.
  input wire logic reg_rd_en,
  input wire logic [sref_pkg::ADDR_W-1:0] reg_rd_addr,
  output logic [sref_pkg::DATA_W-1:0] reg_rd_data,
  output logic reg_rd_valid,
  // Fault sources.
  input wire sref_pkg::sref_evt_s evt,
  input wire sref_pkg::sref_ana_s ana,
  input wire sref_pkg::sref_meas_s meas,
  // Fault handling outputs.
  output logic packet_discard,
  output logic bist_inject,
  output logic bist_busy,
  output logic [sref_pkg::DATA_W-1:0] err_flags
);

  typedef struct packed {
    sref_pkg::sref_ana_s sync1;
    sref_pkg::sref_ana_s sync2;
    logic [15:0] flags;
    logic bist_fail;
    logic [15:0] rd_data;
    logic rd_valid;
    logic discard;
  } sref_state_s;

  sref_state_s q;
  sref_state_s d;

  logic inject;
  logic check;
  logic busy;
  logic rd_hit;
  logic [15:0] cond;
  logic [15:0] clr;
  logic [2:0] hi_code;
  logic [2:0] lo_code;
  logic [1:0] mm_code;

  // Circular distance between two angles, so 359 and 1 degrees are close.
  function automatic logic [15:0] angle_dist(input logic [15:0] a,
                                             input logic [15:0] b);
    logic [15:0] diff;
    diff = a - b;
    angle_dist = diff[15] ? 16'(~diff + 16'h0001) : diff;
  endfunction : angle_dist

  // True when a temperature code lies outside the valid range.
  function automatic logic temp_bad(input logic signed [11:0] t);
    temp_bad = (t < sref_pkg::TEMP_MIN_CODE) ||
               (t > sref_pkg::TEMP_MAX_CODE);
  endfunction : temp_bad

  // Absolute difference of two temperature codes.
  function automatic logic [12:0] temp_dist(input logic signed [11:0] a,
                                            input logic signed [11:0] b);
    logic signed [12:0] diff;
    diff = 13'(a) - 13'(b);
    temp_dist = diff[12] ? 13'(-diff) : 13'(diff);
  endfunction : temp_dist

  sref_bist u_bist (
    .clk(clk),
    .resetn(resetn),
    .start(evt.lp_exit),
    .inject(inject),
    .check(check),
    .busy(busy)
  );

  assign hi_code = meas.nv_thr_word[sref_pkg::NV_HI_LSB +: 3];
  assign lo_code = meas.nv_thr_word[sref_pkg::NV_LO_LSB +: 3];
  assign mm_code = meas.nv_thr_word[sref_pkg::NV_MM_LSB +: 2];
  assign rd_hit = reg_rd_en && (reg_rd_addr == sref_pkg::ERR_ADDR);

  // Raw fault vector; the comparator terms take the injection directly.
  always_comb begin
    cond = 16'h0000;
    cond[sref_pkg::BIT_IFACE] = evt.spi_invalid || evt.manchester_err;
    cond[sref_pkg::BIT_XEXEC] = evt.ext_exec_fail;
    cond[sref_pkg::BIT_XOVF] = evt.ext_overflow;
    cond[sref_pkg::BIT_SHADOW] = evt.shadow_misr_err;
    cond[sref_pkg::BIT_UNCORR] = evt.load_multi_err;
    cond[sref_pkg::BIT_SOFT] = evt.load_single_err;
    cond[sref_pkg::BIT_RESET] = evt.load_done || inject;
    cond[sref_pkg::BIT_OVCC] = q.sync2.overvoltage;
    cond[sref_pkg::BIT_UVCC] = q.sync2.undervoltage;
    cond[sref_pkg::BIT_FHIGH] = inject ||
      (meas.field_mag > sref_pkg::FIELD_HI_TABLE[hi_code]);
    cond[sref_pkg::BIT_FLOW] = inject ||
      (meas.field_mag < sref_pkg::FIELD_LO_TABLE[lo_code]);
    cond[sref_pkg::BIT_MISM] = inject ||
      (angle_dist(meas.angle_pri, meas.angle_sec) >
       sref_pkg::MISM_TABLE[mm_code]);
    cond[sref_pkg::BIT_OSC] =
      q.sync2.hf_osc_fault || q.sync2.lf_osc_fault;
    cond[sref_pkg::BIT_SAT] = evt.saturation;
    cond[sref_pkg::BIT_TEMP] = inject ||
      temp_bad(meas.temp_pri) || temp_bad(meas.temp_sec) ||
      (temp_dist(meas.temp_pri, meas.temp_sec) >
       sref_pkg::TEMP_DIFF_CODE);
    cond[sref_pkg::BIT_VREF] = q.sync2.vref_fault;
  end

  // Reset-only flags are kept out of the read clear.
  assign clr = rd_hit ? ~sref_pkg::RESET_ONLY_MASK : 16'h0000;

  always_comb begin
    d = q;
    // The first flop feeds only the second.
    d.sync1 = ana;
    d.sync2 = q.sync1;
    d.rd_valid = rd_hit;
    if (rd_hit) begin
      d.rd_data = q.flags;
    end
    // Injected values are test stimulus and set no flags while busy; the synchronised analog ones still latch for two cycles after.
    if (busy) begin
      d.flags = q.flags & ~clr;
    end else begin
      d.flags = (q.flags & ~clr) | cond;
    end
    // A wake-time test must see every input high or the path is stuck.
    if (check && (cond != 16'hFFFF) ) begin
      d.bist_fail = 1'b1;
    end
    if (q.bist_fail) begin
      d.flags[sref_pkg::BIT_MISM] = 1'b1;
    end
    d.discard = evt.spi_invalid;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      q.sync1 <= '0;
      q.sync2 <= '0;
      q.flags <= sref_pkg::FLAGS_RESET;
      q.bist_fail <= 1'b0;
      q.rd_data <= 16'h0000;
      q.rd_valid <= 1'b0;
      q.discard <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign reg_rd_data = q.rd_data;
  assign reg_rd_valid = q.rd_valid;
  assign packet_discard = q.discard;
  assign bist_inject = inject;
  assign bist_busy = busy;
  assign err_flags = q.flags;

endmodule : sref_flags_top

// ### hdl/sref_pkg.sv
// Package with constants and types for the redundant error-flag register.
package sref_pkg;

  // Register map.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] ERR_ADDR = 8'h12;

  // Flag positions.
  localparam int BIT_IFACE = 15;
  localparam int BIT_XEXEC = 14;
  localparam int BIT_XOVF = 13;
  localparam int BIT_SHADOW = 12;
  localparam int BIT_UNCORR = 11;
  localparam int BIT_SOFT = 10;
  localparam int BIT_RESET = 9;
  localparam int BIT_OVCC = 8;
  localparam int BIT_UVCC = 7;
  localparam int BIT_FHIGH = 6;
  localparam int BIT_FLOW = 5;
  localparam int BIT_MISM = 4;
  localparam int BIT_OSC = 3;
  localparam int BIT_SAT = 2;
  localparam int BIT_TEMP = 1;
  localparam int BIT_VREF = 0;

  // Reset value and the flags that only a reset clears.
  localparam logic [15:0] FLAGS_RESET = 16'h0200;
  localparam logic [15:0] RESET_ONLY_MASK = 16'h1800;

  // Nonvolatile threshold fields in the word at extended address 0x24.
  localparam logic [7:0] NV_THR_ADDR = 8'h24;
  localparam int NV_HI_LSB = 7;
  localparam int NV_LO_LSB = 10;
  localparam int NV_MM_LSB = 13;

  // Threshold tables indexed by the field codes; plain default values.
  localparam logic [7:0][15:0] FIELD_HI_TABLE = {
    16'hF000, 16'hE000, 16'hD000, 16'hC000,
    16'hB000, 16'hA000, 16'h9000, 16'h8000};
  localparam logic [7:0][15:0] FIELD_LO_TABLE = {
    16'h4000, 16'h3800, 16'h3000, 16'h2800,
    16'h2000, 16'h1800, 16'h1000, 16'h0800};
  localparam logic [3:0][15:0] MISM_TABLE = {
    16'h0800, 16'h0400, 16'h0200, 16'h0100};

  // Temperature limits in degrees and the code scale (code/8 + 25).
  localparam int TEMP_MIN_C = -71;
  localparam int TEMP_MAX_C = 185;
  localparam int TEMP_DIFF_C = 20;
  localparam int TEMP_OFFSET_C = 25;
  localparam int TEMP_LSB_PER_C = 8;
  localparam logic signed [11:0] TEMP_MIN_CODE =
    12'((TEMP_MIN_C - TEMP_OFFSET_C) * TEMP_LSB_PER_C);
  localparam logic signed [11:0] TEMP_MAX_CODE =
    12'((TEMP_MAX_C - TEMP_OFFSET_C) * TEMP_LSB_PER_C);
  localparam logic [12:0] TEMP_DIFF_CODE =
    13'(TEMP_DIFF_C * TEMP_LSB_PER_C);

  // Self-test settling time, covering the two-flop synchronisers.
  localparam logic [3:0] BIST_SETTLE_CYC = 4'h4;

  typedef enum logic [1:0] {
    SREF_IDLE = 2'b00,
    SREF_INJECT = 2'b01,
    SREF_CHECK = 2'b10
  } sref_bist_e;

  // One-cycle events and levels from logic on the core clock.
  typedef struct packed {
    logic spi_invalid;
    logic manchester_err;
    logic ext_exec_fail;
    logic ext_overflow;
    logic shadow_misr_err;
    logic load_done;
    logic load_multi_err;
    logic load_single_err;
    logic saturation;
    logic lp_exit;
  } sref_evt_s;

  // Levels from analog monitors, asynchronous to the core clock.
  typedef struct packed {
    logic overvoltage;
    logic undervoltage;
    logic hf_osc_fault;
    logic lf_osc_fault;
    logic vref_fault;
  } sref_ana_s;

  // Measurements and the nonvolatile threshold word.
  typedef struct packed {
    logic [15:0] field_mag;
    logic [15:0] angle_pri;
    logic [15:0] angle_sec;
    logic signed [11:0] temp_pri;
    logic signed [11:0] temp_sec;
    logic [15:0] nv_thr_word;
  } sref_meas_s;

endpackage : sref_pkg

// ### test/sref_flags_props.sv
// Port assertions for the redundant error-flag register.
`timescale 1ns/1ps
module sref_flags_props (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Register read port.
  input wire logic reg_rd_en,
  input wire logic [sref_pkg::ADDR_W-1:0] reg_rd_addr,
  input wire logic [sref_pkg::DATA_W-1:0] reg_rd_data,
  input wire logic reg_rd_valid,
  // Fault sources and results.
  input wire sref_pkg::sref_evt_s evt,
  input wire sref_pkg::sref_ana_s ana,
  input wire logic packet_discard,
  input wire logic bist_busy,
  input wire logic [sref_pkg::DATA_W-1:0] err_flags
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic hit;
  assign hit = reg_rd_en && (reg_rd_addr == sref_pkg::ERR_ADDR);
  // Analog faults cross two synchroniser flops before they latch.
  sequence ov_seen;
    ana.overvoltage && !bist_busy ##1 !bist_busy [*2];
  endsequence
  sequence boot_test;
    bist_busy [*6] ##1 !bist_busy;
  endsequence
  rd_answer_a:
    assert property (hit |=> reg_rd_valid)
      else $error("Read got no answer.");
  rd_stray_a:
    assert property (reg_rd_valid |-> $past(hit))
      else $error("Answer without a read.");
  rd_data_a:
    assert property (hit |=> reg_rd_data == $past(err_flags))
      else $error("Read data is not the pre-read flags.");
  flag_sticky_a:
    assert property (!hit |=> ($past(err_flags) & ~err_flags) == 16'h0000)
      else $error("Flag dropped without a read.");
  mem_keep_a:
    assert property (hit |=> ($past(err_flags) & ~err_flags &
      sref_pkg::RESET_ONLY_MASK) == 16'h0000)
      else $error("Reset-only flag cleared by a read.");
  ovf_set_a:
    assert property (evt.ext_overflow && !bist_busy |=> err_flags[13])
      else $error("Overflow flag not set.");
  ovf_clear_a:
    assert property (hit && !evt.ext_overflow && !bist_busy
      |=> !err_flags[13])
      else $error("Overflow flag not cleared by a read.");
  iface_set_a:
    assert property (evt.spi_invalid && !bist_busy
      |=> packet_discard && err_flags[15])
      else $error("Bad packet not flagged and dropped.");
  ov_set_a:
    assert property (ov_seen |=> err_flags[8])
      else $error("Overvoltage flag not set.");
  boot_a:
    assert property ($rose(resetn)
      |-> err_flags == sref_pkg::FLAGS_RESET ##0 boot_test)
      else $error("Wrong reset value or self-test length.");
endmodule : sref_flags_props

bind sref_flags_top sref_flags_props sref_flags_props_inst (
  .clk(clk), .resetn(resetn), .reg_rd_en(reg_rd_en),
  .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data),
  .reg_rd_valid(reg_rd_valid), .evt(evt), .ana(ana),
  .packet_discard(packet_discard), .bist_busy(bist_busy),
  .err_flags(err_flags));

// ### test/sref_host_model.sv
// Host model that issues register reads to the error-flag block.
`timescale 1ns/1ps
module sref_host_model (
  // Clock and traffic enable.
  input wire logic clk,
  input wire logic rand_go,
  // Read request.
  output logic rd_en,
  output logic [7:0] rd_addr
);
  initial begin
    rd_en = 1'b0;
    rd_addr = 8'h00;
  end
  // Random one-cycle reads, back to back allowed, some unmapped.
  always @(negedge clk) begin
    if (rand_go) begin
      rd_en <= ($urandom % 3) == 0;
      rd_addr <= ($urandom % 4 == 0) ? 8'($urandom) : sref_pkg::ERR_ADDR;
    end
  end
  // The idle address is inverted so a stale value is never trusted.
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(negedge clk);
    rd_en <= 1'b0;
    rd_addr <= ~a;
  endtask : rd
endmodule : sref_host_model

// ### test/tb.sv
// Self-checking bench for the redundant error-flag register.
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic rand_go = 1'b0, resp_ok = 1'b1, rnd = 1'b0, m_on = 1'b0;
  logic rd_en, rd_vld, discard, inj, exp_vld;
  logic [7:0] rd_addr;
  logic [15:0] rd_data, flags, mflags, exp_rd, r16;
  logic [4:0] s1, s2;
  sref_pkg::sref_evt_s evt, evt_v = '0;
  sref_pkg::sref_ana_s ana, ana_v = '0;
  sref_pkg::sref_meas_s meas;
  int bad_count = 0, n_tests = 0;
  always #50 clk = ~clk;
  // The event and analog sources answer the self-test while it injects and resp_ok is set.
  assign evt = (inj && resp_ok) ? '1 : evt_v;
  assign ana = (inj && resp_ok) ? '1 : ana_v;
  sref_flags_top sref_flags_top_inst (.clk(clk), .resetn(resetn),
    .reg_rd_en(rd_en), .reg_rd_addr(rd_addr), .reg_rd_data(rd_data),
    .reg_rd_valid(rd_vld), .evt(evt), .ana(ana), .meas(meas),
    .packet_discard(discard), .bist_inject(inj), .bist_busy(),
    .err_flags(flags));
  sref_host_model sref_host_model_inst (.clk(clk), .rand_go(rand_go),
    .rd_en(rd_en), .rd_addr(rd_addr));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [15:0] cnd(sref_pkg::sref_evt_s e,
      logic [4:0] a, sref_pkg::sref_meas_s m);
    int d, tp, ts, lo, hi, df;
    d = int'(16'(m.angle_pri - m.angle_sec));
    if (d > 32768) d = 65536 - d;
    tp = int'(m.temp_pri);
    ts = int'(m.temp_sec);
    lo = int'(sref_pkg::TEMP_MIN_CODE);
    hi = int'(sref_pkg::TEMP_MAX_CODE);
    df = int'(sref_pkg::TEMP_DIFF_CODE);
    return {e.spi_invalid | e.manchester_err, e.ext_exec_fail,
      e.ext_overflow, e.shadow_misr_err, e.load_multi_err,
      e.load_single_err, e.load_done, a[4], a[3],
      m.field_mag > sref_pkg::FIELD_HI_TABLE[m.nv_thr_word[9:7]],
      m.field_mag < sref_pkg::FIELD_LO_TABLE[m.nv_thr_word[12:10]],
      d > int'(sref_pkg::MISM_TABLE[m.nv_thr_word[14:13]]), a[2] | a[1],
      e.saturation, tp < lo || tp > hi || ts < lo || ts > hi ||
      tp - ts > df || ts - tp > df, a[0]};
  endfunction : cnd
  // Reference model; a fault in a read cycle wins over the clear.
  always @(posedge clk) begin : model
    logic hit;
    hit = rd_en && rd_addr == sref_pkg::ERR_ADDR;
    exp_vld = hit && resetn;
    if (hit) exp_rd = mflags;
    if (m_on) mflags = (hit ? mflags & sref_pkg::RESET_ONLY_MASK : mflags)
      | cnd(evt, s2, meas);
    s2 = s1;
    s1 = ana;
  end
  always @(negedge clk) begin
    if (m_on) begin
      chk(flags, mflags);
      chk({15'h0000, rd_vld}, {15'h0000, exp_vld});
      if (exp_vld) chk(rd_data, exp_rd);
    end
    if (rnd) begin
      r16 = 16'($urandom);
      evt_v <= 10'($urandom & $urandom & $urandom) & 10'h3FE;
      ana_v <= 5'($urandom & $urandom);
      meas <= {16'($urandom), r16, r16 + 16'($urandom % 4096),
        12'($urandom % 2400) - 12'h400, 12'($urandom % 2400) - 12'h400,
        16'($urandom)};
    end
  end
  task automatic rd(input logic [7:0] a);
    sref_host_model_inst.rd(a);
  endtask : rd
  // Ana residue after the self-test is design-specific, so it is masked.
  task automatic sync_up;
    m_on = 1'b0;
    mflags = '0;
    resetn <= 1'b0;
    repeat (5) @(negedge clk);
    resetn <= 1'b1;
    repeat (12) @(negedge clk);
    chk(flags & 16'hFE76, sref_pkg::FLAGS_RESET);
    rd(sref_pkg::ERR_ADDR);
    chk(rd_data & 16'hFE76, sref_pkg::FLAGS_RESET);
    rd(sref_pkg::ERR_ADDR);
    chk(rd_data, 16'h0000);
    @(negedge clk);
    m_on = 1'b1;
  endtask : sync_up
  task automatic lp_test(input logic ok, input logic [15:0] e);
    m_on = 1'b0;
    resp_ok = ok;
    evt_v = 10'h001;
    @(negedge clk);
    evt_v = '0;
    repeat (12) @(negedge clk);
    rd(sref_pkg::ERR_ADDR);
    rd(sref_pkg::ERR_ADDR);
    chk(rd_data & 16'h0010, e);
  endtask : lp_test
  task automatic wrap_up;
    if (bad_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up
  initial begin
    #(100 * 5000);
    bad_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(85763));
    meas = '0;
    meas.field_mag = 16'h6000;
    sync_up();
    rd(8'h13);
    evt_v = 10'h240;
    rd(sref_pkg::ERR_ADDR);
    evt_v = '0;
    rd(sref_pkg::ERR_ADDR);
    rand_go = 1'b1;
    rnd = 1'b1;
    repeat (400) @(negedge clk);
    rnd = 1'b0;
    rand_go = 1'b0;
    @(negedge clk);
    evt_v = '0;
    ana_v = '0;
    meas = '0;
    meas.field_mag = 16'h6000;
    repeat (4) rd(sref_pkg::ERR_ADDR);
    lp_test(1'b1, 16'h0000);
    lp_test(1'b0, 16'h0010);
    resp_ok = 1'b1;
    sync_up();
    wrap_up();
  end
endmodule : tb
